// ### fap_flash_model.sv
module fap_flash_model
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fetch port
    input  wire logic             rd_i,
    input  wire logic [31:0]      addr_i,
    output logic      [7:0]       data_o,
    output logic                  dvalid_o,
    // Stored settings image and answer speed
    input  wire logic [19:0][7:0] image_i,
    input  wire logic             slow_i,
    output logic                  order_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed
    {
        logic [4:0] idx;
        logic [1:0] wcnt;
        logic       dv;
        logic [7:0] data;
        logic       ok;
    } fap_fl_st_t;

    fap_fl_st_t  st_reg;
    fap_fl_st_t  st_next;
    logic [31:0] exp_addr;

    // Control byte and ID at the first location, ROM word at the second
    assign exp_addr = (st_reg.idx < 5'h10) ? 32'hFFFFFFA0 + 32'(st_reg.idx)
                                          : 32'hFFFFFF8C + 32'(st_reg.idx);

    always_comb
    begin
        st_next      = st_reg;
        st_next.dv   = 1'h0;
        // Bus is not held between bytes, so a stale byte can never pass
        st_next.data = ~st_reg.data;
        if (rd_i && !st_reg.dv)
        begin
            if (slow_i && st_reg.wcnt != 2'h3)
                st_next.wcnt = st_reg.wcnt + 2'h1;
            else
            begin
                st_next.wcnt = 2'h0;
                st_next.dv   = 1'h1;
                st_next.data = image_i[st_reg.idx];
                st_next.idx  = st_reg.idx + 5'h01;
                if (addr_i !== exp_addr)
                    st_next.ok = 1'h0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_reg <= '{5'h00, 2'h0, 1'h0, 8'hA5, 1'h1};
        else
            st_reg <= st_next;
    end

    assign data_o     = st_reg.data;
    assign dvalid_o   = st_reg.dv;
    assign order_ok_o = st_reg.ok;
endmodule

// ### fap_id_mem.sv
module fap_id_mem
    import fap_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Write port
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Registered read port
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } fap_mem_st_t;

    fap_mem_st_t st_reg;
    fap_mem_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = st_reg.mem[raddr_i];
        if (we_i)
        begin
            st_next.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;

endmodule

// ### fap_pkg.sv
package fap_pkg;

    // Fixed flash locations of the protection settings
    localparam logic [31:0] FAP_CTRL_ADDR  = 32'hFFFFFFA0;
    localparam logic [31:0] FAP_ROM_ADDR   = 32'hFFFFFF9C;

    // Layout of the fetched settings, in fetch order
    localparam int          FAP_ID_BYTES   = 15;
    localparam int          FAP_ROM_BYTES  = 4;
    localparam logic [4:0]  FAP_IDX_ID0    = 5'h01;
    localparam logic [4:0]  FAP_IDX_ROM0   = 5'h10;
    localparam logic [4:0]  FAP_IDX_LAST   = 5'h13;
    localparam logic [3:0]  FAP_CNT_LAST   = 4'hF;

    // Setting values
    localparam logic [7:0]  FAP_LOCK_CTRL  = 8'h52;
    localparam logic [7:0]  FAP_OPEN_CTRL  = 8'hFF;
    localparam logic [7:0]  FAP_PAD_BYTE   = 8'hFF;
    localparam logic [7:0]  FAP_ROM_PROT   = 8'h00;
    localparam int          FAP_SIG_LEN    = 7;
    localparam logic [6:0][7:0] FAP_SIG    = {8'h74, 8'h63, 8'h65, 8'h74, 8'h6F, 8'h72, 8'h50};

    // Reset values
    localparam logic [31:0] FAP_ADDR_RST   = 32'h00000000;
    localparam logic [7:0]  FAP_BYTE_RST   = 8'h00;

    // Source of an authentication request
    localparam logic        FAP_SRC_BOOT   = 1'b0;
    localparam logic        FAP_SRC_DBG    = 1'b1;

    typedef enum logic [2:0]
    {
        FAP_S_FETCH = 3'b000,
        FAP_S_WAIT  = 3'b001,
        FAP_S_IDLE  = 3'b010,
        FAP_S_AUTH  = 3'b011
    } fap_state_t;

endpackage

// ### fap_protect.sv
module fap_protect
    import fap_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    // Clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    // Settings fetch from flash
    output logic                   FLASH_RD_O,
    output logic [31:0]            FLASH_ADDR_O,
    input  wire logic [7:0]        FLASH_DATA_I,
    input  wire logic              FLASH_DVALID_I,
    // Start mode strap
    input  wire logic              BOOT_MODE_I,
    // ID authentication
    input  wire logic              ID_START_I,
    input  wire logic              ID_SRC_I,
    input  wire logic              ID_VALID_I,
    input  wire logic [7:0]        ID_BYTE_I,
    output logic                   AUTH_PASS_O,
    output logic                   AUTH_FAIL_O,
    output logic                   HOST_ACCESS_O,
    output logic                   DBG_ACCESS_O,
    // Parallel programmer requests
    input  wire logic              PP_REQ_I,
    output logic                   PP_GRANT_O,
    output logic                   PP_REFUSE_O,
    // Access window and self-programming
    input  wire logic              AW_SET_I,
    input  wire logic [ADDR_W-1:0] AW_START_I,
    input  wire logic [ADDR_W-1:0] AW_END_I,
    input  wire logic              AW_LOCK_I,
    input  wire logic              SP_REQ_I,
    input  wire logic [ADDR_W-1:0] SP_ADDR_I,
    output logic                   SP_GRANT_O,
    output logic                   SP_REJECT_O,
    output logic                   AW_LOCKED_O,
    // Status
    output logic                   READY_O,
    output logic                   FULL_LOCK_O
);

    typedef struct packed
    {
        fap_state_t        state;
        logic [4:0]        idx;
        logic [7:0]        ctrl;
        logic              sig_ok;
        logic              rom_zero;
        logic              ready;
        logic              full_lock;
        logic              boot;
        logic [31:0]       addr;
        logic              rd;
        logic [3:0]        cnt;
        logic              mism;
        logic              pend;
        logic [7:0]        pend_byte;
        logic              src;
        logic              host_ok;
        logic              dbg_ok;
        logic              pass;
        logic              fail;
        logic              pp_grant;
        logic              pp_refuse;
        logic [ADDR_W-1:0] aw_start;
        logic [ADDR_W-1:0] aw_end;
        logic              aw_valid;
        logic              aw_locked;
        logic              sp_grant;
        logic              sp_reject;
    } fap_st_t;

    fap_st_t    st_reg;
    fap_st_t    st_next;
    logic       mem_we;
    logic [3:0] mem_waddr;
    logic [7:0] mem_rdata;
    logic [7:0] sig_expect;
    logic [3:0] id_pos;
    logic       src_allowed;
    logic       outside;

    // Stored ID, compared one byte at a time so no wide comparator is needed
    fap_id_mem #(
        .WIDTH (8),
        .DEPTH (16),
        .AW    (4)
    ) u_id_mem (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (FLASH_DATA_I),
        .raddr_i (st_reg.cnt),
        .rdata_o (mem_rdata)
    );

    always_comb
    begin
        id_pos     = 4'(st_reg.idx - FAP_IDX_ID0);
        mem_waddr  = id_pos;
        mem_we     = (st_reg.state == FAP_S_WAIT) && FLASH_DVALID_I
                     && (st_reg.idx >= FAP_IDX_ID0) && (st_reg.idx < FAP_IDX_ROM0);
        sig_expect = (int'(id_pos) < FAP_SIG_LEN) ? FAP_SIG[id_pos[2:0]] : FAP_PAD_BYTE;
        src_allowed = (ID_SRC_I == FAP_SRC_BOOT) ? st_reg.boot : !st_reg.boot;
        outside    = (SP_ADDR_I < st_reg.aw_start) || (SP_ADDR_I > st_reg.aw_end);
    end

    always_comb
    begin
        st_next           = st_reg;
        st_next.pass      = 1'b0;
        st_next.fail      = 1'b0;
        st_next.pp_grant  = 1'b0;
        st_next.pp_refuse = 1'b0;
        st_next.sp_grant  = 1'b0;
        st_next.sp_reject = 1'b0;
        st_next.pend      = 1'b0;

        case (st_reg.state)
            FAP_S_FETCH:
            begin
                st_next.rd = 1'b1;
                if (st_reg.idx < FAP_IDX_ROM0)
                begin
                    st_next.addr = FAP_CTRL_ADDR + 32'(st_reg.idx);
                end
                else
                begin
                    st_next.addr = FAP_ROM_ADDR + 32'(st_reg.idx - FAP_IDX_ROM0);
                end
                st_next.state = FAP_S_WAIT;
            end
            FAP_S_WAIT:
            begin
                if (FLASH_DVALID_I)
                begin
                    st_next.rd = 1'b0;
                    if (st_reg.idx == 5'h00)
                    begin
                        st_next.ctrl = FLASH_DATA_I;
                    end
                    else if (st_reg.idx < FAP_IDX_ROM0)
                    begin
                        st_next.sig_ok = st_reg.sig_ok && (FLASH_DATA_I == sig_expect);
                    end
                    else
                    begin
                        st_next.rom_zero = st_reg.rom_zero && (FLASH_DATA_I == FAP_ROM_PROT);
                    end
                    if (st_reg.idx == FAP_IDX_LAST)
                    begin
                        // Strap caught once, at the end of the fetch
                        st_next.boot      = BOOT_MODE_I;
                        st_next.ready     = 1'b1;
                        st_next.full_lock = st_reg.sig_ok && st_next.rom_zero
                                            && (st_reg.ctrl == FAP_LOCK_CTRL);
                        st_next.state     = FAP_S_IDLE;
                    end
                    else
                    begin
                        st_next.idx   = st_reg.idx + 5'h01;
                        st_next.state = FAP_S_FETCH;
                    end
                end
            end
            FAP_S_IDLE, FAP_S_AUTH:
            begin
                if (ID_START_I)
                begin
                    if (!src_allowed)
                    begin
                        st_next.fail = 1'b1;
                    end
                    else if ((st_reg.ctrl == FAP_OPEN_CTRL) && !st_reg.full_lock)
                    begin
                        st_next.pass = 1'b1;
                        st_next.host_ok = st_reg.host_ok || (ID_SRC_I == FAP_SRC_BOOT);
                        st_next.dbg_ok  = st_reg.dbg_ok || (ID_SRC_I == FAP_SRC_DBG);
                        st_next.state   = FAP_S_IDLE;
                    end
                    else
                    begin
                        // A new attempt withdraws the access of that source
                        st_next.src   = ID_SRC_I;
                        st_next.cnt   = 4'h0;
                        st_next.mism  = 1'b0;
                        st_next.state = FAP_S_AUTH;
                        if (ID_SRC_I == FAP_SRC_BOOT)
                        begin
                            st_next.host_ok = 1'b0;
                        end
                        else
                        begin
                            st_next.dbg_ok = 1'b0;
                        end
                    end
                end
                else if (st_reg.state == FAP_S_AUTH)
                begin
                    if (ID_VALID_I && (st_reg.cnt != FAP_CNT_LAST))
                    begin
                        st_next.pend      = 1'b1;
                        st_next.pend_byte = ID_BYTE_I;
                        st_next.cnt       = st_reg.cnt + 4'h1;
                    end
                    if (st_reg.pend)
                    begin
                        st_next.mism = st_reg.mism || (st_reg.pend_byte != mem_rdata);
                        if (st_reg.cnt == FAP_CNT_LAST)
                        begin
                            if (st_next.mism || st_reg.full_lock)
                            begin
                                st_next.fail = 1'b1;
                                st_next.cnt  = 4'h0;
                                st_next.mism = 1'b0;
                            end
                            else
                            begin
                                st_next.pass    = 1'b1;
                                st_next.state   = FAP_S_IDLE;
                                st_next.host_ok = st_reg.host_ok || (st_reg.src == FAP_SRC_BOOT);
                                st_next.dbg_ok  = st_reg.dbg_ok || (st_reg.src == FAP_SRC_DBG);
                            end
                        end
                    end
                end
            end
            default:
            begin
                st_next.state = FAP_S_FETCH;
            end
        endcase

        // Requests before the settings are in are refused, never let through
        if (PP_REQ_I)
        begin
            st_next.pp_refuse = !st_reg.ready || st_reg.rom_zero;
            st_next.pp_grant  = st_reg.ready && !st_reg.rom_zero;
        end

        if (st_reg.ready && AW_SET_I && (!st_reg.aw_locked || st_reg.boot))
        begin
            st_next.aw_start = AW_START_I;
            st_next.aw_end   = AW_END_I;
            st_next.aw_valid = 1'b1;
        end
        if (st_reg.ready && AW_LOCK_I)
        begin
            st_next.aw_locked = 1'b1;
        end
        if (SP_REQ_I)
        begin
            st_next.sp_reject = !st_reg.ready || (st_reg.aw_valid && outside);
            st_next.sp_grant  = st_reg.ready && !(st_reg.aw_valid && outside);
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_reg          <= '0;
            st_reg.state    <= FAP_S_FETCH;
            st_reg.ctrl     <= FAP_BYTE_RST;
            st_reg.addr     <= FAP_ADDR_RST;
            st_reg.sig_ok   <= 1'b1;
            st_reg.rom_zero <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign FLASH_RD_O    = st_reg.rd;
    assign FLASH_ADDR_O  = st_reg.addr;
    assign AUTH_PASS_O   = st_reg.pass;
    assign AUTH_FAIL_O   = st_reg.fail;
    assign HOST_ACCESS_O = st_reg.host_ok;
    assign DBG_ACCESS_O  = st_reg.dbg_ok;
    assign PP_GRANT_O    = st_reg.pp_grant;
    assign PP_REFUSE_O   = st_reg.pp_refuse;
    assign SP_GRANT_O    = st_reg.sp_grant;
    assign SP_REJECT_O   = st_reg.sp_reject;
    assign AW_LOCKED_O   = st_reg.aw_locked;
    assign READY_O       = st_reg.ready;
    assign FULL_LOCK_O   = st_reg.full_lock;

    property p_lock_load;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(READY_O) |-> (FULL_LOCK_O == ($past(st_reg.sig_ok) && st_reg.rom_zero
                                            && (st_reg.ctrl == FAP_LOCK_CTRL)));
    endproperty
    a_lock_load: assert property (p_lock_load) else $error("Full lock load wrong");

    property p_lock_stays;
        @(posedge CLK_I) disable iff (RST_I)
        FULL_LOCK_O |=> FULL_LOCK_O && READY_O;
    endproperty
    a_lock_stays: assert property (p_lock_stays) else $error("Full lock dropped");

    property p_lock_host;
        @(posedge CLK_I) disable iff (RST_I)
        FULL_LOCK_O |-> !HOST_ACCESS_O && !AUTH_PASS_O;
    endproperty
    a_lock_host: assert property (p_lock_host) else $error("Host access under lock");

    property p_lock_dbg;
        @(posedge CLK_I) disable iff (RST_I)
        FULL_LOCK_O |-> !DBG_ACCESS_O;
    endproperty
    a_lock_dbg: assert property (p_lock_dbg) else $error("Debugger access under lock");

    property p_pp_refuse;
        @(posedge CLK_I) disable iff (RST_I)
        PP_REQ_I && st_reg.rom_zero |=> PP_REFUSE_O && !PP_GRANT_O;
    endproperty
    a_pp_refuse: assert property (p_pp_refuse) else $error("Programmer not refused");

    property p_fetch_addr;
        @(posedge CLK_I) disable iff (RST_I)
        (st_reg.state == FAP_S_WAIT) && (st_reg.idx == FAP_IDX_ROM0)
            |-> FLASH_ADDR_O == FAP_ROM_ADDR && FLASH_RD_O;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("ROM word address wrong");

    property p_host_mode;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(HOST_ACCESS_O) |-> st_reg.boot && AUTH_PASS_O;
    endproperty
    a_host_mode: assert property (p_host_mode) else $error("Host granted outside boot");

    property p_dbg_mode;
        @(posedge CLK_I) disable iff (RST_I)
        $rose(DBG_ACCESS_O) |-> !st_reg.boot && AUTH_PASS_O;
    endproperty
    a_dbg_mode: assert property (p_dbg_mode) else $error("Debugger granted in boot");

    property p_window;
        @(posedge CLK_I) disable iff (RST_I)
        SP_REQ_I && st_reg.aw_valid && outside |=> SP_REJECT_O && !SP_GRANT_O;
    endproperty
    a_window: assert property (p_window) else $error("Outside write not rejected");

    property p_aw_frozen;
        @(posedge CLK_I) disable iff (RST_I)
        AW_LOCKED_O && !st_reg.boot |=> $stable(st_reg.aw_start) && $stable(st_reg.aw_end);
    endproperty
    a_aw_frozen: assert property (p_aw_frozen) else $error("Locked window changed");

    property p_aw_boot;
        @(posedge CLK_I) disable iff (RST_I)
        AW_SET_I && READY_O && st_reg.boot |=> st_reg.aw_start == $past(AW_START_I);
    endproperty
    a_aw_boot: assert property (p_aw_boot) else $error("Boot window set lost");

endmodule

// ### fap_protect_tb.sv
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module fap_protect_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fap_pkg::*;

    logic clk, rst, f_rd, f_dv, boot, id_start, id_src, id_valid, a_pass, a_fail;
    logic h_acc, d_acc, pp_req, pp_g, pp_r, aw_set, aw_lock, sp_req, sp_g, sp_r;
    logic aw_lkd, ready, flock, slow, ord_ok, got_p, got_f, p, f;
    logic [31:0]      f_addr, aw_s, aw_e, sp_addr;
    logic [7:0]       f_data, id_byte;
    logic [19:0][7:0] img;
    logic [7:0]       dev_id [15];
    logic [7:0]       bad_id [15];
    logic [7:0]       lock_id [15];
    int               n_fail, num_checks;

    fap_protect dut_u (.CLK_I(clk), .RST_I(rst), .FLASH_RD_O(f_rd), .FLASH_ADDR_O(f_addr),
        .FLASH_DATA_I(f_data), .FLASH_DVALID_I(f_dv), .BOOT_MODE_I(boot),
        .ID_START_I(id_start), .ID_SRC_I(id_src), .ID_VALID_I(id_valid), .ID_BYTE_I(id_byte),
        .AUTH_PASS_O(a_pass), .AUTH_FAIL_O(a_fail), .HOST_ACCESS_O(h_acc),
        .DBG_ACCESS_O(d_acc), .PP_REQ_I(pp_req), .PP_GRANT_O(pp_g), .PP_REFUSE_O(pp_r),
        .AW_SET_I(aw_set), .AW_START_I(aw_s), .AW_END_I(aw_e), .AW_LOCK_I(aw_lock),
        .SP_REQ_I(sp_req), .SP_ADDR_I(sp_addr), .SP_GRANT_O(sp_g), .SP_REJECT_O(sp_r),
        .AW_LOCKED_O(aw_lkd), .READY_O(ready), .FULL_LOCK_O(flock));

    fap_flash_model flash_u (.clk_i(clk), .rst_i(rst), .rd_i(f_rd), .addr_i(f_addr),
        .data_o(f_data), .dvalid_o(f_dv), .image_i(img), .slow_i(slow), .order_ok_o(ord_ok));

    always #12.5 clk = ~clk;

    // Result pulses last one cycle, so they are caught here and kept
    always @(posedge clk)
    begin
        if (a_pass) got_p <= 1'h1;
        if (a_fail) got_f <= 1'h1;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic set_img(input logic [7:0] c, input logic [7:0] id [15], input logic [31:0] r);
        img[0] = c;
        for (int k = 0; k < 15; k++) img[k + 1] = id[k];
        for (int k = 0; k < 4; k++) img[16 + k] = r[8 * k +: 8];
    endtask

    task automatic do_reset(input logic b, input logic s);
        rst <= 1'h1;
        boot <= b;
        slow <= s;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        for (int k = 0; k < 500 && ready !== 1'h1; k++) @(posedge clk);
        #1;
        `CHK(ready, 1'h1)
        `CHK(ord_ok, 1'h1)
    endtask

    task automatic auth(input logic s, input logic [7:0] id [15], input int nb,
                        output logic op, output logic of);
        @(posedge clk);
        got_p = 1'h0;
        got_f = 1'h0;
        id_start <= 1'h1;
        id_src <= s;
        @(posedge clk);
        id_start <= 1'h0;
        for (int i = 0; i < nb; i++)
        begin
            id_valid <= 1'h1;
            id_byte <= id[i];
            @(posedge clk);
        end
        id_valid <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        op = got_p;
        of = got_f;
    endtask

    task automatic pulse_pp(output logic g, output logic r);
        @(posedge clk);
        pp_req <= 1'h1;
        @(posedge clk);
        pp_req <= 1'h0;
        #1;
        g = pp_g;
        r = pp_r;
    endtask

    task automatic sp(input logic [31:0] a, input logic exp_g);
        @(posedge clk);
        sp_req <= 1'h1;
        sp_addr <= a;
        @(posedge clk);
        sp_req <= 1'h0;
        #1;
        `CHK({sp_g, sp_r}, {exp_g, ~exp_g})
    endtask

    task automatic win(input logic [31:0] s, input logic [31:0] e, input logic lk);
        @(posedge clk);
        aw_set <= !lk;
        aw_lock <= lk;
        aw_s <= s;
        aw_e <= e;
        @(posedge clk);
        aw_set <= 1'h0;
        aw_lock <= 1'h0;
    endtask

    task automatic t_boot();
        set_img(8'hFF, dev_id, 32'h12345678);
        do_reset(1'h1, 1'h1);
        `CHK(flock, 1'h0)
        auth(FAP_SRC_BOOT, bad_id, 0, p, f);
        `CHK({p, f, h_acc}, 3'h5)
        pulse_pp(p, f);
        `CHK({p, f}, 2'h2)
        set_img(8'h45, dev_id, 32'h00000000);
        do_reset(1'h1, 1'h0);
        pulse_pp(p, f);
        `CHK({p, f}, 2'h1)
        auth(FAP_SRC_BOOT, bad_id, 15, p, f);
        `CHK({p, f, h_acc}, 3'h2)
        auth(FAP_SRC_BOOT, dev_id, 15, p, f);
        `CHK({p, f, h_acc}, 3'h5)
        auth(FAP_SRC_DBG, dev_id, 0, p, f);
        `CHK({p, f, d_acc}, 3'h2)
        $display("boot-mode test done");
    endtask

    task automatic t_dbg();
        do_reset(1'h0, 1'h1);
        auth(FAP_SRC_DBG, bad_id, 15, p, f);
        `CHK({p, f, d_acc}, 3'h2)
        auth(FAP_SRC_DBG, dev_id, 15, p, f);
        `CHK({p, f, d_acc}, 3'h5)
        auth(FAP_SRC_BOOT, dev_id, 0, p, f);
        `CHK({p, f, h_acc}, 3'h2)
        $display("debugger test done");
    endtask

    task automatic t_lock();
        set_img(FAP_LOCK_CTRL, lock_id, 32'h00000000);
        do_reset(1'h1, 1'h0);
        `CHK(flock, 1'h1)
        auth(FAP_SRC_BOOT, lock_id, 15, p, f);
        `CHK({p, f}, 2'h1)
        auth(FAP_SRC_BOOT, lock_id, 15, p, f);
        `CHK({p, f, h_acc}, 3'h2)
        pulse_pp(p, f);
        `CHK({p, f}, 2'h1)
        do_reset(1'h0, 1'h1);
        `CHK(flock, 1'h1)
        auth(FAP_SRC_DBG, lock_id, 15, p, f);
        `CHK({p, f, d_acc}, 3'h2)
        lock_id[14] = 8'hFE;
        set_img(FAP_LOCK_CTRL, lock_id, 32'h00000000);
        do_reset(1'h0, 1'h0);
        `CHK(flock, 1'h0)
        $display("full-lock test done");
    endtask

    task automatic t_window();
        set_img(8'hFF, dev_id, 32'h00000001);
        do_reset(1'h0, 1'h0);
        sp(32'h00002000, 1'h1);
        win(32'h00001000, 32'h00001FFF, 1'h0);
        sp(32'h00000FFF, 1'h0);
        sp(32'h00001000, 1'h1);
        sp(32'h00001FFF, 1'h1);
        sp(32'h00002000, 1'h0);
        win(32'h00000000, 32'h00000000, 1'h1);
        #1;
        `CHK(aw_lkd, 1'h1)
        win(32'h00000000, 32'h0000FFFF, 1'h0);
        sp(32'h00002000, 1'h0);
        do_reset(1'h1, 1'h0);
        win(32'h00001000, 32'h00001FFF, 1'h0);
        win(32'h00000000, 32'h00000000, 1'h1);
        win(32'h00000000, 32'h0000FFFF, 1'h0);
        sp(32'h00002000, 1'h1);
        $display("window test done");
    endtask

    initial
    begin
        clk = 1'h0;
        {rst, boot, id_start, id_src, id_valid, pp_req, aw_set, aw_lock, sp_req} = '0;
        {id_byte, aw_s, aw_e, sp_addr, slow, img, got_p, got_f} = '0;
        n_fail = 0;
        num_checks = 0;
        for (int k = 0; k < 15; k++)
        begin
            dev_id[k] = 8'(k + 1);
            bad_id[k] = 8'(k + 1);
            lock_id[k] = (k < FAP_SIG_LEN) ? FAP_SIG[k] : FAP_PAD_BYTE;
        end
        bad_id[14] = 8'h0E;
        t_boot();
        t_dbg();
        t_lock();
        t_window();
        test_done();
    end

    // Whole run needs a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule
